// File: design/rrb_pkg.sv
// Constants shared by the receive ring-buffer store block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package rrb_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int IRQ_PULSE_NS   = 500;
  localparam int IRQ_PULSE_CYC  = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_PTRBASE = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BUF_SEL_BIT     = 4;
  localparam int RX_MASK_BIT     = 11;
  localparam int TX_MASK_BIT     = 10;
  localparam int BUSY_BIT        = 1;
  localparam int PROTO_B_BIT     = 0;
  localparam logic [4:0]  CONFIG_RST  = 5'h03;
  localparam logic [15:0] CONTROL_RST = 16'h0c00;
  localparam logic [15:0] PTRBASE_RST = 16'h0000;
  // ****************************************************************
  // Pointer block entries and command word fields
  // ****************************************************************
  localparam logic [5:0] SINGLE_ENTRY = 6'h1f;
  localparam logic [3:0] MIN_EXPONENT = 4'h3;
  localparam int SA_LSB   = 5;
  localparam int TR_BIT   = 10;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1f;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {ST_IDLE, ST_FETCH, ST_ID, ST_DATA, ST_TAG, ST_WB, ST_END} rrb_state_t;
endpackage

// File: design/rrb_store.sv
// Receive ring-buffer store with end-of-activity interrupts.
// Assumes message events arrive from decoder logic on the same clock and
// that the shared memory port acknowledges each request with memAck.
module rrb_store
  import rrb_pkg::*;
#(
  parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
  input  wire logic        clk,          // System clock, 10 MHz.
  input  wire logic        reset_n,      // Asynchronous reset, active low.
  input  wire logic [31:0] s_axi_awaddr, // Write address.
  input  wire logic        s_axi_awvalid,// Write address valid.
  output logic             s_axi_awready,// Write address ready.
  input  wire logic [31:0] s_axi_wdata,  // Write data.
  input  wire logic [3:0]  s_axi_wstrb,  // Write byte strobes.
  input  wire logic        s_axi_wvalid, // Write data valid.
  output logic             s_axi_wready, // Write data ready.
  output logic [1:0]       s_axi_bresp,  // Write response.
  output logic             s_axi_bvalid, // Write response valid.
  input  wire logic        s_axi_bready, // Write response ready.
  input  wire logic [31:0] s_axi_araddr, // Read address.
  input  wire logic        s_axi_arvalid,// Read address valid.
  output logic             s_axi_arready,// Read address ready.
  output logic [31:0]      s_axi_rdata,  // Read data.
  output logic [1:0]       s_axi_rresp,  // Read response.
  output logic             s_axi_rvalid, // Read data valid.
  input  wire logic        s_axi_rready, // Read data ready.
  input  wire logic        cmdValid,     // Pulse: valid command word.
  input  wire logic [15:0] cmdWord,      // Command word, bit time 4 in bit 15.
  input  wire logic        wordValid,    // Received data word offered.
  input  wire logic [15:0] wordData,     // Received data word.
  output logic             wordReady,    // Data word taken when high with valid.
  input  wire logic        msgEnd,       // Pulse: end of message activity.
  input  wire logic        msgError,     // Pulse: error, illegal or superseded.
  input  wire logic [15:0] timeTag,      // Time tag register value.
  output logic             memReq,       // Memory access request.
  output logic             memWe,        // High for a store.
  output logic [15:0]      memAddr,      // Memory word address.
  output logic [15:0]      memWdata,     // Store data.
  input  wire logic        memAck,       // Access done.
  input  wire logic [15:0] memRdata,     // Fetch data, valid with memAck.
  output logic             end_of_message_irq_n,      // Pin output level.
  output logic             end_of_message_irq_oe_n,   // Low while pulling low.
  output logic             end_of_mode_code_irq_n,    // Pin output level.
  output logic             end_of_mode_code_irq_oe_n  // Low while pulling low.
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [4:0]  base_pointer_config_r;
  logic [15:0] control_word_r;
  logic [15:0] ptrBase_r;
  logic [15:0] lastPtr_r;
  rrb_state_t  state_r;
  logic [15:0] ctr_r;
  logic [15:0] cmd_r;
  logic [15:0] tag_r;
  logic [5:0]  entry_r;
  logic        endSeen_r;
  logic        errSeen_r;
  logic        isRx_r;
  logic        isMode_r;
  logic [7:0]  eomCnt_r;
  logic [7:0]  mcCnt_r;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    mergeLanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  wire        wrTake   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire        rdTake   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [7:0]  wrOfs    = s_axi_awaddr[7:0];
  wire [7:0]  rdOfs    = s_axi_araddr[7:0];
  wire        wrHit    = (s_axi_awaddr[31:8] == 24'h000000) &&
                         (wrOfs == OFS_CONFIG || wrOfs == OFS_CONTROL || wrOfs == OFS_PTRBASE);
  wire        rdHit    = (s_axi_araddr[31:8] == 24'h000000) &&
                         (rdOfs == OFS_CONFIG || rdOfs == OFS_CONTROL ||
                          rdOfs == OFS_PTRBASE || rdOfs == OFS_STATUS);
  wire [15:0] cfgMerge = mergeLanes({11'h000, base_pointer_config_r}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] rdMux    = (rdOfs == OFS_CONFIG)  ? {27'h0000000, base_pointer_config_r} :
                         (rdOfs == OFS_CONTROL) ? {16'h0000, control_word_r} :
                         (rdOfs == OFS_PTRBASE) ? {16'h0000, ptrBase_r} :
                         (rdOfs == OFS_STATUS)  ? {lastPtr_r, 15'h0000, state_r != ST_IDLE} :
                         32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready         <= 1'b0;
      s_axi_wready          <= 1'b0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= RESP_OKAY;
      s_axi_arready         <= 1'b0;
      s_axi_rvalid          <= 1'b0;
      s_axi_rresp           <= RESP_OKAY;
      s_axi_rdata           <= 32'h00000000;
      base_pointer_config_r <= CONFIG_RST;
      control_word_r        <= CONTROL_RST;
      ptrBase_r             <= PTRBASE_RST;
    end else begin
      s_axi_awready <= wrTake;
      s_axi_wready  <= wrTake;
      s_axi_arready <= rdTake;
      if (wrTake) begin
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        if (wrOfs == OFS_CONFIG && wrHit) begin
          base_pointer_config_r <= cfgMerge[4:0];
        end
        if (wrOfs == OFS_CONTROL && wrHit) begin
          control_word_r <= mergeLanes(control_word_r, s_axi_wdata, s_axi_wstrb);
        end
        if (wrOfs == OFS_PTRBASE && wrHit) begin
          ptrBase_r <= mergeLanes(ptrBase_r, s_axi_wdata, s_axi_wstrb) & 16'hffc0;
        end
      end else if (s_axi_awready) begin
        // The response follows the address and data handshakes, never joins them.
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdTake) begin
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata  <= rdMux;
      end else if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pointer selection and ring counter
  // ****************************************************************
  wire        bufferSelect        = base_pointer_config_r[BUF_SEL_BIT];
  wire [3:0]  buffer_size_exponent = (base_pointer_config_r[3:0] < MIN_EXPONENT) ?
                                     MIN_EXPONENT : base_pointer_config_r[3:0];
  wire [15:0] sizeMask   = 16'hffff >> (5'h10 - {1'b0, buffer_size_exponent});
  wire [15:0] ctrInc     = ctr_r + 16'h0001;
  // Only the bits covered by the buffer size ripple; the base stays put.
  wire [15:0] ctrNext    = (ctr_r & ~sizeMask) | (ctrInc & sizeMask);
  wire [4:0]  cmdSa      = cmdWord[SA_LSB +: 5];
  wire        cmdMode    = (cmdSa == SA_MODE_LO) || (cmdSa == SA_MODE_HI);
  wire        cmdRx      = !cmdWord[TR_BIT] && !cmdMode;
  wire [5:0]  cmdEntry   = bufferSelect ? SINGLE_ENTRY : {1'b0, cmdSa};
  wire [15:0] entryAddr  = ptrBase_r | {10'h000, entry_r};
  wire        ackNow     = memReq && memAck;
  wire        storeDone  = ackNow && memWe && (state_r == ST_ID || state_r == ST_DATA ||
                                               state_r == ST_TAG);
  wire        busyBlock  = control_word_r[PROTO_B_BIT] && control_word_r[BUSY_BIT];
  wire        irqAllowed = !errSeen_r && !msgError && !busyBlock;
  wire        eomEnable  = isRx_r ? control_word_r[RX_MASK_BIT] :
                                    control_word_r[TX_MASK_BIT];
  wire        endNow     = endSeen_r || msgEnd;

  // ****************************************************************
  // Message sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      memReq    <= 1'b0;
      memWe     <= 1'b0;
      memAddr   <= 16'h0000;
      memWdata  <= 16'h0000;
      wordReady <= 1'b0;
      ctr_r     <= 16'h0000;
      cmd_r     <= 16'h0000;
      tag_r     <= 16'h0000;
      entry_r   <= 6'h00;
      endSeen_r <= 1'b0;
      errSeen_r <= 1'b0;
      isRx_r    <= 1'b0;
      isMode_r  <= 1'b0;
      lastPtr_r <= 16'h0000;
    end else begin
      wordReady <= 1'b0;
      if (msgError) begin
        errSeen_r <= 1'b1;
      end
      if (msgEnd && state_r != ST_IDLE) begin
        endSeen_r <= 1'b1;
        tag_r     <= timeTag;
      end
      if (storeDone) begin
        ctr_r <= ctrNext;
      end
      if (ackNow) begin
        memReq <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (cmdValid) begin
            cmd_r     <= cmdWord;
            entry_r   <= cmdEntry;
            isRx_r    <= cmdRx;
            isMode_r  <= cmdMode;
            errSeen_r <= msgError;
            endSeen_r <= 1'b0;
            if (cmdRx) begin
              state_r <= ST_FETCH;
              memReq  <= 1'b1;
              memWe   <= 1'b0;
              memAddr <= ptrBase_r | {10'h000, cmdEntry};
            end else begin
              state_r <= ST_WB;
            end
          end
        end
        ST_FETCH: begin
          if (ackNow) begin
            ctr_r    <= memRdata;
            state_r  <= ST_ID;
            memReq   <= 1'b1;
            memWe    <= 1'b1;
            memAddr  <= memRdata;
            memWdata <= cmd_r;
          end
        end
        ST_ID: begin
          if (ackNow) begin
            state_r   <= ST_DATA;
            wordReady <= 1'b1;
          end
        end
        ST_DATA: begin
          if (wordReady && wordValid) begin
            memReq   <= 1'b1;
            memAddr  <= ctr_r;
            memWdata <= wordData;
          end else if (!memReq && endNow) begin
            state_r  <= ST_TAG;
            memReq   <= 1'b1;
            memAddr  <= ctr_r;
            memWdata <= endSeen_r ? tag_r : timeTag;
          end else if (!memReq || ackNow) begin
            wordReady <= !endNow;
          end
        end
        ST_TAG: begin
          if (ackNow) begin
            state_r  <= ST_WB;
            memReq   <= 1'b1;
            memAddr  <= entryAddr;
            memWdata <= ctrNext;
          end
        end
        ST_WB: begin
          if (!isRx_r && endNow) begin
            state_r <= ST_END;
          end else if (isRx_r && ackNow) begin
            lastPtr_r <= memWdata;
            state_r   <= ST_END;
          end
        end
        ST_END: begin
          state_r   <= ST_IDLE;
          endSeen_r <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Open-drain interrupt pulses
  // ****************************************************************
  wire eomFire = (state_r == ST_END) && !isMode_r && eomEnable && irqAllowed;
  wire mcFire  = (state_r == ST_END) && isMode_r && irqAllowed;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eomCnt_r <= 8'h00;
      mcCnt_r  <= 8'h00;
    end else begin
      eomCnt_r <= eomFire ? PULSE_CYC[7:0] : (eomCnt_r != 8'h00 ? eomCnt_r - 8'h01 : 8'h00);
      mcCnt_r  <= mcFire ? PULSE_CYC[7:0] : (mcCnt_r != 8'h00 ? mcCnt_r - 8'h01 : 8'h00);
    end
  end

  // The pins only ever pull low; the pull-up makes the high level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      end_of_message_irq_n      <= 1'b0;
      end_of_message_irq_oe_n   <= 1'b1;
      end_of_mode_code_irq_n    <= 1'b0;
      end_of_mode_code_irq_oe_n <= 1'b1;
    end else begin
      end_of_message_irq_n      <= 1'b0;
      end_of_mode_code_irq_n    <= 1'b0;
      end_of_message_irq_oe_n   <= !(eomFire || eomCnt_r > 8'h01);
      end_of_mode_code_irq_oe_n <= !(mcFire || mcCnt_r > 8'h01);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_wrap_keeps_base: assert property (@(posedge clk) disable iff (!reset_n)
    storeDone |=> ((ctr_r & ~sizeMask) == ($past(ctr_r) & ~$past(sizeMask))))
    else $error("Ring counter changed bits above the buffer size.");
  chk_ctr_steps_one: assert property (@(posedge clk) disable iff (!reset_n)
    storeDone |=> (((ctr_r - $past(ctr_r)) & sizeMask) == 16'h0001))
    else $error("Ring counter did not step by one after a store.");
  chk_single_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_FETCH && bufferSelect) |-> (memAddr[5:0] == SINGLE_ENTRY && !memWe))
    else $error("Single buffer mode fetched the wrong entry.");
  chk_sep_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_FETCH && !bufferSelect) |-> (memAddr[5:0] == {1'b0, cmd_r[9:5]}))
    else $error("Separate buffer mode fetched the wrong entry.");
  chk_writeback_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_WB && memReq) |-> (memAddr == entryAddr && memWe && memWdata == ctr_r))
    else $error("Pointer write back went to the wrong place.");
  chk_id_word: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_r == ST_ID) |-> (memWdata == cmd_r && memAddr == $past(memRdata)))
    else $error("Identification word is not the command word.");
  chk_eom_masked: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(end_of_message_irq_oe_n) |-> $past(eomEnable && irqAllowed && !isMode_r))
    else $error("End of message pulse despite mask or error.");
  chk_mc_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    mcFire |=> !end_of_mode_code_irq_oe_n ##1 (mcCnt_r == 8'(PULSE_CYC - 1)))
    else $error("Mode code pulse missing or mistimed.");
  chk_pull_low_only: assert property (@(posedge clk) disable iff (!reset_n)
    !end_of_message_irq_oe_n |-> (!end_of_message_irq_n && (eomCnt_r != 8'h00)))
    else $error("Interrupt pin driven outside a pulse.");
  chk_tag_after_data: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_TAG && ackNow) |=> (state_r == ST_WB && memAddr == entryAddr))
    else $error("Time tag not followed by pointer write back.");
endmodule

// File: test/rrb_host_mem.sv
// Host memory model on the far side of the shared memory port.
// Assumes one request at a time, held by the device until acknowledged.
module rrb_host_mem (
  input  wire logic        clk,      // System clock.
  input  wire logic        memReq,   // Access request.
  input  wire logic        memWe,    // High for a store.
  input  wire logic [15:0] memAddr,  // Word address.
  input  wire logic [15:0] memWdata, // Store data.
  input  wire logic        slow,     // Adds random wait cycles.
  output logic             memAck,   // Access done.
  output logic [15:0]      memRdata  // Fetch data.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:65535];
  int          waitCnt;
  initial begin
    memAck   = 1'b0;
    memRdata = 16'h0000;
    waitCnt  = 0;
  end
  // Read data toggles except on a fetch acknowledge so a stale value is never mistaken for a fetch.
  always @(posedge clk) begin
    memRdata <= ~memRdata;
    if (memAck || !memReq) begin
      memAck  <= 1'b0;
      waitCnt <= slow ? $urandom_range(0, 3) : 0;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end else begin
      memAck <= 1'b1;
      if (memWe) mem[memAddr] <= memWdata;
      else memRdata <= mem[memAddr];
    end
  end
endmodule

// File: test/rrb_store_tb_top.sv
// Self-checking bench for the receive ring-buffer store block.
// Assumes the host memory model and the design package are compiled first.
module rrb_store_tb_top
  import rrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          PULSE = 3;
  localparam logic [15:0] PBASE = 16'h0440;
  logic        clk, reset_n, cmdValid, wordValid, msgEnd, msgError, slow, wordReady;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] cmdWord, wordData, timeTag, memAddr, memWdata, memRdata;
  logic        memReq, memWe, memAck, emVal, emOen, mcVal, mcOen;
  wire         emPin = emOen ? 1'b1 : emVal;
  wire         mcPin = mcOen ? 1'b1 : mcVal;
  int          miscompares, checkCount, emLow, mcLow;
  logic [15:0] ptr [0:31];
  logic [15:0] dw [0:31];
  rrb_store #(.PULSE_CYC(PULSE)) dut_u (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmdValid, .cmdWord, .wordValid, .wordData, .wordReady,
    .msgEnd, .msgError, .timeTag, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata,
    .end_of_message_irq_n(emVal), .end_of_message_irq_oe_n(emOen),
    .end_of_mode_code_irq_n(mcVal), .end_of_mode_code_irq_oe_n(mcOen));
  rrb_host_mem mem_u (.clk, .memReq, .memWe, .memAddr, .memWdata, .slow, .memAck, .memRdata);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (emPin === 1'b0) emLow++;
    if (mcPin === 1'b0) mcLow++;
  end
  // ********
  // Helpers
  // ********
  function automatic logic [15:0] wrap_add(logic [15:0] p, int k, int e);
    logic [15:0] m;
    m = (16'h1 << e) - 16'h1;
    return (p & ~m) | ((p + 16'(k)) & m);
  endfunction
  task automatic finish_test();
    if (miscompares == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_edge(inout int n);
    @(posedge clk);
    n++;
    if (n > 1000) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      wait_edge(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      wait_edge(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One message of kind 0 receive, 1 transmit, 2 mode code, with random masks and faults.
  task automatic run_msg(input int kind, input int iter);
    logic [15:0] cmd, ctl, tag, p, wb, x, a;
    logic [31:0] d;
    logic [1:0]  r;
    logic [4:0]  sa, ent;
    logic        sel, err, sup, tr;
    int          fld, e, nw, n, em0, mc0, emExp, mcExp;
    fld = $urandom_range(3, 5);
    e   = fld;
    sel = 1'($urandom_range(0, 1));
    err = ($urandom_range(0, 4) == 0);
    ctl = 16'($urandom_range(0, 3) << 10) | 16'($urandom_range(0, 3));
    sup = err || (ctl[1:0] == 2'b11);
    tr  = (kind == 1) || (kind == 2 && $urandom_range(0, 1) == 1);
    sa  = (kind == 2) ? {5{$urandom_range(0, 1) == 1}} : 5'($urandom_range(1, 30));
    cmd = {5'($urandom_range(0, 31)), tr, sa, 5'($urandom_range(0, 31))};
    ent = sel ? SINGLE_ENTRY[4:0] : sa;
    // One shared length must hold the data words plus two.
    nw  = (kind != 0) ? 0 : (iter % 4 == 0) ? (1 << e) - 2 : $urandom_range(0, (1 << e) - 2);
    tag = 16'($urandom);
    for (int i = 0; i < nw; i++) dw[i] = 16'($urandom);
    axi_wr({24'h0, OFS_CONFIG}, {27'h0, sel, 4'(fld)}, 4'hf, r);
    axi_wr({24'h0, OFS_CONTROL}, {16'h0, ctl}, 4'hf, r);
    em0 = emLow;
    mc0 = mcLow;
    n   = 0;
    @(posedge clk);
    cmdWord  <= cmd;
    cmdValid <= 1'b1;
    timeTag  <= tag;
    @(posedge clk);
    cmdValid <= 1'b0;
    if (nw > 0) wordValid <= 1'b1;
    for (int i = 0; i < nw; i++) begin
      wordData <= dw[i];
      do wait_edge(n); while (!wordReady);
    end
    if (nw > 0) wordValid <= 1'b0;
    msgError <= err;
    msgEnd   <= 1'b1;
    @(posedge clk);
    msgEnd   <= 1'b0;
    msgError <= 1'b0;
    do begin
      axi_rd({24'h0, OFS_STATUS}, d, r);
      wait_edge(n);
    end while (d[0]);
    repeat (PULSE + 4) @(posedge clk);
    emExp = sup ? 0 : (kind == 0) ? int'(ctl[RX_MASK_BIT]) :
            (kind == 1) ? int'(ctl[TX_MASK_BIT]) : 0;
    mcExp = (!sup && kind == 2) ? 1 : 0;
    chk("message pulse cycles", 32'(emExp * PULSE),
        32'(emLow - em0));
    chk("mode pulse cycles", 32'(mcExp * PULSE),
        32'(mcLow - mc0));
    if (kind == 0) begin
      p = ptr[ent];
      for (int k = 0; k < nw + 2; k++) begin
        x = (k == 0) ? cmd : (k == nw + 1) ? tag : dw[k - 1];
        a = wrap_add(p, k, e);
        chk("stored word", x, mem_u.mem[a]);
      end
      wb = wrap_add(p, nw + 2, e);
      chk("written-back pointer", wb, mem_u.mem[PBASE | ent]);
      chk("status pointer", wb, d[31:16]);
      if (sel) chk("untouched entry", ptr[sa], mem_u.mem[PBASE | sa]);
      ptr[ent] = wb;
    end
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {clk, reset_n, cmdValid, wordValid, msgEnd, msgError, slow} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {cmdWord, wordData, timeTag} = '0;
    {miscompares, checkCount, emLow, mcLow} = '0;
    void'($urandom(49));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    axi_rd({24'h0, OFS_CONFIG}, d, r);
    chk("config reset", {27'h0, CONFIG_RST}, d);
    axi_rd({24'h0, OFS_CONTROL}, d, r);
    chk("control reset", {16'h0, CONTROL_RST}, d);
    axi_rd({24'h0, OFS_PTRBASE}, d, r);
    chk("base reset", {16'h0, PTRBASE_RST}, d);
    axi_wr({24'h0, OFS_CONTROL}, 32'hffff_ffff, 4'h1, r);
    axi_rd({24'h0, OFS_CONTROL}, d, r);
    chk("control low byte", 32'h0000_0cff, d);
    axi_wr({24'h0, OFS_PTRBASE}, 32'hffff_047f, 4'hf, r);
    axi_rd({24'h0, OFS_PTRBASE}, d, r);
    chk("pointer base", {16'h0, PBASE}, d);
    axi_wr({24'h0, OFS_STATUS}, 32'h0000_0001, 4'hf, r);
    chk("status write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(32'h1000_0000, 32'h0000_0001, 4'hf, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(32'h0000_0010, d, r);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    // Initial pointers sit on 64-word boundaries, wide enough for every size used.
    for (int i = 1; i < 32; i++) begin
      ptr[i] = 16'h2000 + 16'(i * 64);
      mem_u.mem[PBASE | 16'(i)] = ptr[i];
    end
    for (int i = 0; i < 60; i++) begin
      slow <= i[0];
      run_msg(i % 3, i);
    end
    finish_test();
  end
  initial begin
    #(60000 * 100);
    miscompares++;
    finish_test();
  end
endmodule
